// *** deint_ctrl_pkg.sv ***
// Purpose: shared constants and carriers of the deinterlacer run-time control
// Assumes: one clock, synchronous active-low reset
// Notes:   offsets are word offsets on the slave port
package deint_ctrl_pkg;

   typedef enum logic [1:0] {CTRL_NONE, CTRL_BLEND, CTRL_RATE} ctrl_mode_t;

   localparam int ADDR_W = 2;
   localparam int DATA_W = 32;
   localparam int COEF_W = 16;
   localparam int RATE_W = 8;
   localparam int ACC_W  = 10;

   localparam logic [ADDR_W-1:0] OFS_RUN    = 2'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 2'h1;
   localparam logic [ADDR_W-1:0] OFS_VAL_A  = 2'h2;
   localparam logic [ADDR_W-1:0] OFS_VAL_B  = 2'h3;

   localparam int RUN_BIT      = 0;
   localparam int STATUS_BIT   = 0;
   localparam int OVERRIDE_BIT = 0;

   localparam logic [COEF_W-1:0] COEF_RESET = 16'h0000;
   localparam logic [RATE_W-1:0] RATE_RESET = 8'h00;
   localparam logic [ACC_W-1:0]  ACC_RESET  = 10'h000;
   localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              chipselect;
      logic              write;
      logic [DATA_W-1:0] writedata;
   } slave_req_t;

   typedef struct packed {
      logic              overrideOn;
      logic [COEF_W-1:0] blendCoef;
      logic [RATE_W-1:0] inRate;
      logic [RATE_W-1:0] outRate;
   } frame_ctrl_t;

   typedef struct packed {
      logic       frameWrite;
      logic [1:0] fieldFetchCount;
      logic       motionRead;
      logic       motionWrite;
      logic       separateClocks;
   } master_cfg_t;

   typedef struct packed {
      logic              go;
      logic              overrideOn;
      logic [COEF_W-1:0] blendCoef;
      logic [RATE_W-1:0] inRate;
      logic [RATE_W-1:0] outRate;
      frame_ctrl_t       lat;
      logic              busy;
      logic              draining;
      logic [ACC_W-1:0]  acc;
      logic              tick;
      logic              readDone;
      logic [DATA_W-1:0] readData;
   } ctrl_state_t;

endpackage

// *** deinterlacer_runtime_control.sv ***
// Purpose: run-time register port of the deinterlacer and its frame-boundary latching
// Assumes: frameReq held until frameAck; frameDone a one-cycle pulse
// Notes:   the mode parameter admits only one control port at a time
`timescale 1ns/1ns
module deinterlacer_runtime_control
   import deint_ctrl_pkg::*;
#(
   parameter ctrl_mode_t MODE            = CTRL_BLEND,
   parameter bit         BUFFERED        = 1'b1,
   parameter bit         MOTION_ADAPTIVE = 1'b1,
   parameter bit         MOTION_BLEED    = 1'b0,
   parameter bit         SEPARATE_CLOCKS = 1'b0
) (
   input  wire logic              clk,          // core clock, 10 MHz
   input  wire logic              rst_n,        // synchronous reset, low active
   input  wire slave_req_t        slaveReq,     // control slave request
   output logic [DATA_W-1:0]      readdata,     // control slave read data
   output logic                   waitrequest,  // control slave stall
   input  wire logic              frameReq,     // core wants to start a frame
   output logic                   frameAck,     // frame start granted, values latched
   input  wire logic              frameDone,    // frame finished pulse
   output frame_ctrl_t            frameCtrl,    // values latched for current frame
   output logic                   outFrameTick, // rate mode: emit one output frame
   output master_cfg_t            masterCfg,    // which memory masters exist
   input  wire logic              masterClk,    // separate memory master clock
   input  wire logic              masterRst,    // separate memory master reset, high active
   output logic                   memMasterClk, // clock used by memory masters
   output logic                   memMasterRst  // reset used by memory masters
);

   localparam bit PORT_ON = (MODE != CTRL_NONE);
   localparam bit IS_RATE = (MODE == CTRL_RATE);

   ctrl_state_t stateReg;
   ctrl_state_t stateNext;
   logic        csActive;
   logic        rdStart;

   // word read decode; write-only offsets read back as zero
   function automatic logic [DATA_W-1:0] readWord(input logic [ADDR_W-1:0] a, input ctrl_state_t s);
      logic [DATA_W-1:0] w;
      w = ZERO_WORD;
      unique case (a)
         OFS_RUN:    w[RUN_BIT] = s.go;
         OFS_STATUS: w[STATUS_BIT] = s.busy;
         OFS_VAL_A,
         OFS_VAL_B:  w = ZERO_WORD;
      endcase
      return w;
   endfunction

   // address is a word index, no byte lanes
   assign csActive = PORT_ON && slaveReq.chipselect;
   assign rdStart  = csActive && !slaveReq.write && !stateReg.readDone;

   // one wait state per read so read data can come from a flop
   assign waitrequest = rdStart;
   assign readdata    = stateReg.readData;

   // new frame only while running and no previous one still draining
   assign frameAck = frameReq && stateReg.go && !stateReg.busy && !stateReg.draining;

   assign frameCtrl    = stateReg.lat;
   assign outFrameTick = stateReg.tick;

   // structural presence of the memory masters
   always_comb begin
      masterCfg.frameWrite      = BUFFERED;
      masterCfg.fieldFetchCount = !BUFFERED ? 2'h0 : (MOTION_ADAPTIVE ? 2'h2 : 2'h1);
      masterCfg.motionRead      = BUFFERED && MOTION_ADAPTIVE && MOTION_BLEED;
      masterCfg.motionWrite     = BUFFERED && MOTION_ADAPTIVE && MOTION_BLEED;
      masterCfg.separateClocks  = SEPARATE_CLOCKS;
   end

   // masterRst release is assumed synchronous to masterClk
   assign memMasterClk = SEPARATE_CLOCKS ? masterClk : clk;
   assign memMasterRst = SEPARATE_CLOCKS ? masterRst : !rst_n;

   always_comb begin
      stateNext          = stateReg;
      stateNext.tick     = 1'b0;
      stateNext.readDone = 1'b0;
      if (csActive && slaveReq.write) begin
         unique case (slaveReq.address)
            OFS_RUN:    stateNext.go = slaveReq.writedata[RUN_BIT];
            OFS_STATUS: stateNext.go = stateReg.go;
            OFS_VAL_A: begin
               if (IS_RATE) begin
                  stateNext.inRate = slaveReq.writedata[RATE_W-1:0];
               end else begin
                  stateNext.overrideOn = slaveReq.writedata[OVERRIDE_BIT];
               end
            end
            OFS_VAL_B: begin
               if (IS_RATE) begin
                  stateNext.outRate = slaveReq.writedata[RATE_W-1:0];
               end else begin
                  stateNext.blendCoef = slaveReq.writedata[COEF_W-1:0];
               end
            end
         endcase
      end else if (rdStart) begin
         stateNext.readDone = 1'b1;
         stateNext.readData = readWord(slaveReq.address, stateReg);
      end
      // host writes during a frame only reach the core at the next latch
      if (frameAck) begin
         stateNext.busy           = 1'b1;
         stateNext.lat.overrideOn = IS_RATE ? 1'b0 : stateReg.overrideOn;
         stateNext.lat.blendCoef  = IS_RATE ? COEF_RESET : stateReg.blendCoef;
         stateNext.lat.inRate     = IS_RATE ? stateReg.inRate : RATE_RESET;
         stateNext.lat.outRate    = IS_RATE ? stateReg.outRate : RATE_RESET;
         if (IS_RATE) begin
            stateNext.acc      = ACC_W'(stateReg.acc + {2'h0, stateReg.outRate});
            stateNext.draining = 1'b1;
         end
      end else if (frameDone) begin
         stateNext.busy = 1'b0;
      end
      // accumulator scales with both rates, so only their ratio matters
      if (stateReg.draining) begin
         if (stateReg.lat.inRate != RATE_RESET && stateReg.acc >= {2'h0, stateReg.lat.inRate}) begin
            stateNext.acc  = ACC_W'(stateReg.acc - {2'h0, stateReg.lat.inRate});
            stateNext.tick = 1'b1;
         end else begin
            stateNext.draining = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stateReg.go         <= 1'b0;
         stateReg.overrideOn <= 1'b0;
         stateReg.blendCoef  <= COEF_RESET;
         stateReg.inRate     <= RATE_RESET;
         stateReg.outRate    <= RATE_RESET;
         stateReg.lat        <= '0;
         stateReg.busy       <= 1'b0;
         stateReg.draining   <= 1'b0;
         stateReg.acc        <= ACC_RESET;
         stateReg.tick       <= 1'b0;
         stateReg.readDone   <= 1'b0;
         stateReg.readData   <= ZERO_WORD;
      end else begin
         stateReg <= stateNext;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_halt;
      !stateReg.go |-> !frameAck;
   endproperty
   a_halt: assert property (p_halt) else $error("frame granted while stopped");

   property p_latch;
      frameAck |=> (frameCtrl.blendCoef == (IS_RATE ? COEF_RESET : $past(stateReg.blendCoef)))
                   && (frameCtrl.inRate == (IS_RATE ? $past(stateReg.inRate) : RATE_RESET));
   endproperty
   a_latch: assert property (p_latch) else $error("frame values not latched");

   property p_hold;
      !frameAck |=> $stable(frameCtrl);
   endproperty
   a_hold: assert property (p_hold) else $error("latched values moved mid frame");

   property p_go_read;
      (csActive && !slaveReq.write && stateReg.readDone && slaveReq.address == OFS_RUN)
         |-> readdata == {31'h0, $past(stateReg.go)};
   endproperty
   a_go_read: assert property (p_go_read) else $error("run bit read wrong");

   property p_status_read;
      (csActive && !slaveReq.write && stateReg.readDone && slaveReq.address == OFS_STATUS)
         |-> readdata == {31'h0, $past(stateReg.busy)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_wo_read;
      (rdStart && slaveReq.address[1]) |=> (readdata == ZERO_WORD && !waitrequest);
   endproperty
   a_wo_read: assert property (p_wo_read) else $error("write-only offset read nonzero");

   property p_no_cs;
      !slaveReq.chipselect |=> $stable(stateReg.go) && $stable(stateReg.blendCoef) && $stable(stateReg.inRate);
   endproperty
   a_no_cs: assert property (p_no_cs) else $error("register changed without select");

   property p_coef_write;
      (csActive && slaveReq.write && slaveReq.address == OFS_VAL_B && !IS_RATE)
         |=> stateReg.blendCoef == $past(slaveReq.writedata[COEF_W-1:0]);
   endproperty
   a_coef_write: assert property (p_coef_write) else $error("coefficient not stored");

   property p_ratio;
      (!stateReg.draining && stateReg.lat.inRate != RATE_RESET && IS_RATE)
         |-> stateReg.acc < {2'h0, stateReg.lat.inRate};
   endproperty
   a_ratio: assert property (p_ratio) else $error("rate accumulator left over range");

   property p_read_wait;
      rdStart |=> !waitrequest ##1 (!slaveReq.chipselect || slaveReq.write || waitrequest);
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read handshake length wrong");

   property p_go_write;
      (csActive && slaveReq.write && slaveReq.address == OFS_RUN)
         |=> stateReg.go == $past(slaveReq.writedata[RUN_BIT]);
   endproperty
   a_go_write: assert property (p_go_write) else $error("run bit not stored");

   property p_override_write;
      (csActive && slaveReq.write && slaveReq.address == OFS_VAL_A && !IS_RATE)
         |=> stateReg.overrideOn == $past(slaveReq.writedata[OVERRIDE_BIT]);
   endproperty
   a_override_write: assert property (p_override_write) else $error("override bit not stored");

   property p_in_rate_write;
      (csActive && slaveReq.write && slaveReq.address == OFS_VAL_A && IS_RATE)
         |=> stateReg.inRate == $past(slaveReq.writedata[RATE_W-1:0]);
   endproperty
   a_in_rate_write: assert property (p_in_rate_write) else $error("input rate not stored");

   property p_out_rate_write;
      (csActive && slaveReq.write && slaveReq.address == OFS_VAL_B && IS_RATE)
         |=> stateReg.outRate == $past(slaveReq.writedata[RATE_W-1:0]);
   endproperty
   a_out_rate_write: assert property (p_out_rate_write) else $error("output rate not stored");

   // status is read-only, a write there must leave every register alone
   property p_status_write;
      (csActive && slaveReq.write && slaveReq.address == OFS_STATUS)
         |=> $stable(stateReg.go) && $stable(stateReg.overrideOn) && $stable(stateReg.blendCoef)
             && $stable(stateReg.inRate) && $stable(stateReg.outRate);
   endproperty
   a_status_write: assert property (p_status_write) else $error("status write changed a register");

   property p_write_no_wait;
      (csActive && slaveReq.write) |-> !waitrequest;
   endproperty
   a_write_no_wait: assert property (p_write_no_wait) else $error("write stalled");

   property p_no_cs_values;
      !slaveReq.chipselect |=> $stable(stateReg.overrideOn) && $stable(stateReg.outRate);
   endproperty
   a_no_cs_values: assert property (p_no_cs_values) else $error("value changed without select");

   property p_read_hold;
      !rdStart |=> $stable(readdata);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read data moved without a read");

   property p_busy_set;
      frameAck |=> stateReg.busy;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("status not set on frame start");

   property p_busy_clear;
      (frameDone && !frameAck) |=> !stateReg.busy;
   endproperty
   a_busy_clear: assert property (p_busy_clear) else $error("status not cleared on frame end");

   property p_one_latch;
      (stateReg.busy || stateReg.draining) |-> !frameAck;
   endproperty
   a_one_latch: assert property (p_one_latch) else $error("second latch within a frame");

   property p_latch_blend;
      (frameAck && !IS_RATE)
         |=> frameCtrl.overrideOn == $past(stateReg.overrideOn) && frameCtrl.outRate == RATE_RESET;
   endproperty
   a_latch_blend: assert property (p_latch_blend) else $error("blend values not latched");

   property p_latch_rate;
      (frameAck && IS_RATE) |=> frameCtrl.outRate == $past(stateReg.outRate) && !frameCtrl.overrideOn;
   endproperty
   a_latch_rate: assert property (p_latch_rate) else $error("rate values not latched");

   property p_acc_add;
      (frameAck && IS_RATE)
         |=> stateReg.acc == ACC_W'($past(stateReg.acc) + {2'h0, $past(stateReg.outRate)});
   endproperty
   a_acc_add: assert property (p_acc_add) else $error("output rate not added on frame");

   property p_tick_due;
      (stateReg.draining && stateReg.lat.inRate != RATE_RESET
         && stateReg.acc >= {2'h0, stateReg.lat.inRate}) |=> outFrameTick;
   endproperty
   a_tick_due: assert property (p_tick_due) else $error("output frame tick missing");

   property p_drain_end;
      (stateReg.draining && stateReg.acc < {2'h0, stateReg.lat.inRate}) |=> !stateReg.draining;
   endproperty
   a_drain_end: assert property (p_drain_end) else $error("drain did not stop");

   property p_tick_source;
      outFrameTick |-> $past(stateReg.draining);
   endproperty
   a_tick_source: assert property (p_tick_source) else $error("tick outside a drain");

   property p_blend_no_tick;
      !IS_RATE |-> !outFrameTick;
   endproperty
   a_blend_no_tick: assert property (p_blend_no_tick) else $error("tick in blend build");

   property p_no_buffer;
      !masterCfg.frameWrite
         |-> masterCfg.fieldFetchCount == 2'h0 && !masterCfg.motionRead && !masterCfg.motionWrite;
   endproperty
   a_no_buffer: assert property (p_no_buffer) else $error("master present without buffering");

   property p_no_port;
      !PORT_ON |-> !waitrequest && readdata == ZERO_WORD;
   endproperty
   a_no_port: assert property (p_no_port) else $error("absent port answered");

endmodule

// *** ctrl_host_model.sv ***
// Purpose: host processor on the control slave port
// Assumes: one request at a time, held until waitrequest is low
// Notes:   released address and data lines show the inverse of their last value, chipselect and write go low
`timescale 1ns/1ns
module ctrl_host_model
   import deint_ctrl_pkg::*;
(
   input  wire logic              clk,        // core clock
   output slave_req_t             slaveReq,   // request to the slave
   input  wire logic [DATA_W-1:0] readdata,   // slave read data
   input  wire logic              waitrequest // slave stall
);
   logic timedOut;  // sticky: some transfer never saw waitrequest low

   initial begin
      slaveReq = '0;
      timedOut = 1'b0;
   end

   task automatic xfer(input logic cs, input logic we, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      logic done;
      q = 'x;
      done = 1'b0;
      @(posedge clk);
      #1 slaveReq = '{a, cs, we, d};
      for (int i = 0; i < 8 && !done; i++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) begin
            q = readdata;
            done = 1'b1;
         end
      end
      if (!done) timedOut = 1'b1;
      // no pull-ups on this bus: idle lines must not look valid
      #1 slaveReq = '{~a, 1'b0, 1'b0, ~d};
   endtask
endmodule

// *** deinterlacer_runtime_control_bench.sv ***
// Purpose: self-checking bench of the run-time control block, blend and rate builds
// Assumes: one host shared by both builds, the host waits on the blend build
// Notes:   rate ticks checked as running totals against a divide model
`timescale 1ns/1ns
module deinterlacer_runtime_control_bench
   import deint_ctrl_pkg::*;
;
   logic              clk, rst_n, frameReq, frameDone, masterClk, masterRst;
   slave_req_t        slaveReq;
   logic [DATA_W-1:0] rdB, rdR;
   logic              waitB, ackB, ackR, tickB, tickR, mckB, mrB, mckR, mrR;
   frame_ctrl_t       fcB, fcR;
   master_cfg_t       cfgB, cfgR;
   int                n_errors, comparisons, ticks, expTicks, acc, blendTicks;

   ctrl_host_model i_host (.clk(clk), .slaveReq(slaveReq), .readdata(rdB), .waitrequest(waitB));
   deinterlacer_runtime_control i_dut (.clk(clk), .rst_n(rst_n), .slaveReq(slaveReq),
      .readdata(rdB), .waitrequest(waitB), .frameReq(frameReq), .frameAck(ackB),
      .frameDone(frameDone), .frameCtrl(fcB), .outFrameTick(tickB), .masterCfg(cfgB),
      .masterClk(masterClk), .masterRst(masterRst), .memMasterClk(mckB), .memMasterRst(mrB));
   deinterlacer_runtime_control #(.MODE(CTRL_RATE), .MOTION_BLEED(1'b1), .SEPARATE_CLOCKS(1'b1))
   i_rate (.clk(clk), .rst_n(rst_n), .slaveReq(slaveReq), .readdata(rdR), .waitrequest(),
      .frameReq(frameReq), .frameAck(ackR), .frameDone(frameDone), .frameCtrl(fcR),
      .outFrameTick(tickR), .masterCfg(cfgR), .masterClk(masterClk), .masterRst(masterRst),
      .memMasterClk(mckR), .memMasterRst(mrR));

   task automatic test_done;
      if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [40:0] e, input logic [40:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // a transfer that never completed ends the run
   task automatic host_ok;
      if (i_host.timedOut) begin
         n_errors++;
         test_done;
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      logic [31:0] q;
      i_host.xfer(1'b1, 1'b1, a, d, q);
      host_ok();
   endtask

   // read data is registered and stands until the next read, in both builds
   task automatic rdchk(input logic [1:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      i_host.xfer(1'b1, 1'b0, a, '0, q);
      host_ok();
      chk(nm, 41'(e), 41'(q));
      chk({nm, " rate"}, 41'(e), 41'(rdR));
   endtask

   // a stopped core must refuse every frame start while it asks for 20 cycles
   task automatic halted;
      int n;
      n = 0;
      @(posedge clk) #1 frameReq = 1;
      repeat (20) @(negedge clk) n += int'(ackB !== 1'b0) + int'(ackR !== 1'b0);
      @(posedge clk) #1 frameReq = 0;
      chk("acks while stopped", 0, 41'(n));
   endtask

   task automatic frame(input logic [7:0] inR, input logic [15:0] cf);
      logic        gb, gr;
      frame_ctrl_t eB, eR;
      gb = 0;
      gr = 0;
      eB = '{inR[0], cf, 8'h00, 8'h00};
      eR = '{1'b0, 16'h0000, inR, cf[7:0]};
      wr(OFS_VAL_A, {24'($urandom), inR});
      wr(OFS_VAL_B, {16'($urandom), cf});
      @(posedge clk) #1 frameReq = 1;
      for (int i = 0; i < 50 && !(gb && gr); i++) begin
         @(negedge clk);
         gb |= (ackB === 1'b1);
         gr |= (ackR === 1'b1);
      end
      if (!(gb && gr)) begin
         n_errors++;
         test_done;
      end
      @(posedge clk) #1 frameReq = 0;
      rdchk(OFS_STATUS, 32'h1, "status busy");
      wr(OFS_VAL_A, $urandom);
      wr(OFS_VAL_B, $urandom);
      chk("frameCtrl blend", eB, fcB);
      chk("frameCtrl rate", eR, fcR);
      @(posedge clk) #1 frameDone = 1;
      @(posedge clk) #1 frameDone = 0;
      rdchk(OFS_STATUS, 32'h0, "status idle");
      acc += cf[7:0];
      if (inR != 0) begin
         expTicks += acc / inR;
         acc = acc % inR;
      end
      for (int i = 0; i < 1000 && ticks != expTicks; i++) @(posedge clk);
      chk("tick total", 41'(expTicks), 41'(ticks));
      if (ticks != expTicks) test_done;
   endtask

   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial begin
      masterClk = 0;
      forever #37 masterClk = ~masterClk;
   end
   always @(negedge clk) begin
      if (tickR === 1'b1) ticks++;
      if (tickB !== 1'b0) blendTicks++;
   end
   initial begin
      #5_000_000;
      n_errors++;
      test_done;
   end

   initial begin
      logic [31:0] q;
      void'($urandom(18));
      {rst_n, frameReq, frameDone, masterRst} = 4'b0001;
      {n_errors, comparisons, ticks, expTicks, acc, blendTicks} = '0;
      repeat (10) @(posedge clk);
      #1 rst_n = 1;
      @(posedge masterClk) masterRst <= 1'b0;
      @(posedge clk) #1;
      chk("cfg blend", 41'(6'b110000), 41'(cfgB));
      chk("cfg rate", 41'(6'b110111), 41'(cfgR));
      chk("master clocks", {mckB, mrB, mckR, mrR}, {clk, ~rst_n, masterClk, masterRst});
      for (int a = 0; a < 4; a++) rdchk(2'(a), 32'h0, "reset value");
      chk("frameCtrl reset", 41'h0, {fcB | fcR});
      halted();
      i_host.xfer(1'b0, 1'b1, OFS_RUN, 32'hffff_ffff, q);
      host_ok();
      rdchk(OFS_RUN, 32'h0, "run unselected");
      wr(OFS_RUN, $urandom | 32'h1);
      rdchk(OFS_RUN, 32'h1, "run bit");
      wr(OFS_STATUS, 32'hffff_ffff);
      rdchk(OFS_STATUS, 32'h0, "status write");
      frame(8'd1, 16'h0002);
      frame(8'd2, 16'h0004);
      frame(8'd0, 16'hff00);
      frame(8'hff, 16'h0000);
      frame(8'd3, 16'hffff);
      repeat (6) frame(8'($urandom_range(1, 15)), 16'($urandom));
      rdchk(OFS_VAL_A, 32'h0, "offset 2 read");
      rdchk(OFS_VAL_B, 32'h0, "offset 3 read");
      wr(OFS_RUN, 32'hffff_fffe);
      rdchk(OFS_RUN, 32'h0, "run cleared");
      halted();
      chk("blend ticks", 0, 41'(blendTicks));
      test_done;
   end
endmodule
